// >>> rtl/pdm_map.sv
// Program counter and banked data memory map of a small 8-bit controller core.
`timescale 1ns/10ps
module pdm_map #(
  parameter logic [1:0] PM_SIZE = pdm_pkg::PM_8K
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Fetch control from the pipeline.
  input wire logic pc_advance,
  input wire logic int_take,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_value,
  // Data access from the pipeline.
  input wire logic [6:0] file_ofs,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  // Fetch address and data results.
  output logic [12:0] fetch_addr,
  output logic [7:0] file_rdata,
  output logic [1:0] bank_sel,
  output logic [1:0] phase
);

  // Number of RAM words: four banks of 128 offsets, addressed by bank and offset.
  localparam int RAM_DEPTH = 512;

  // Address mask for the configured program memory size.
  logic [12:0] pm_mask;
  always_comb begin
    case (PM_SIZE)
      pdm_pkg::PM_1K: pm_mask = pdm_pkg::PM_MASK_1K;
      pdm_pkg::PM_2K: pm_mask = pdm_pkg::PM_MASK_2K;
      pdm_pkg::PM_4K: pm_mask = pdm_pkg::PM_MASK_4K;
      default: pm_mask = pdm_pkg::PM_MASK_8K;
    endcase
  end

  // Quarter phase, program counter, status and pointer state.
  pdm_pkg::pdm_phase_t phase_r, phase_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] pointer_r, pointer_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ram [0:RAM_DEPTH-1];

  // Effective data address: bank and offset, or the pointer for the window.
  logic [1:0] eff_bank;
  logic [6:0] eff_ofs;
  logic [8:0] eff_addr;
  logic is_window, is_gpr, is_sfr_pcl, is_sfr_status, is_sfr_ptr, aliased;
  // First RAM offset; the smallest size starts RAM low so bank 1 can alias onto it.
  logic [6:0] gpr_lo;
  // RAM write strobe for the current access.
  logic ram_we;

  // Address decode, done combinationally from the current access.
  always_comb begin
    is_window = (file_ofs == pdm_pkg::OFS_INDIRECT);
    // Direct addressing forms the bank from the status bits, indirect from status bit 7 and pointer bit 7.
    eff_bank = is_window ? {status_r[7], pointer_r[7]}
                         : status_r[pdm_pkg::BANK_SEL_HI_BIT:pdm_pkg::BANK_SEL_LO_BIT];
    eff_ofs = is_window ? pointer_r[6:0] : file_ofs;
    // A pointer aimed at the window itself reads as zero and writes nothing.
    aliased = (PM_SIZE == pdm_pkg::PM_1K) && (eff_bank == pdm_pkg::BANK1)
              && (eff_ofs >= pdm_pkg::OFS_ALIAS_LO) && (eff_ofs <= pdm_pkg::OFS_ALIAS_HI);
    if (aliased) begin
      eff_bank = pdm_pkg::BANK0;
    end
    // Core registers appear at the same offset in every bank, one physical copy.
    is_sfr_pcl = (eff_ofs == pdm_pkg::OFS_PCL);
    is_sfr_status = (eff_ofs == pdm_pkg::OFS_STATUS);
    is_sfr_ptr = (eff_ofs == pdm_pkg::OFS_POINTER);
    // The aliased bank 1 range must land on real bank 0 RAM, never on storage that
    // only bank 1 can see, so the smallest size keeps RAM from the alias floor up.
    gpr_lo = (PM_SIZE == pdm_pkg::PM_1K) ? pdm_pkg::OFS_ALIAS_LO : pdm_pkg::OFS_GPR_LO;
    is_gpr = (eff_ofs >= gpr_lo);
    eff_addr = {eff_bank, eff_ofs};
  end

  // Next-state logic for phase, program counter and core registers.
  always_comb begin
    phase_nxt = pdm_pkg::pdm_phase_t'(phase_r + 2'h1);
    pc_nxt = pc_r;
    status_nxt = status_r;
    pointer_nxt = pointer_r;
    rdata_nxt = rdata_r;
    // RAM is written only at the end of the fourth quarter and never during reset.
    ram_we = !rst && (phase_r == pdm_pkg::PH_Q4) && file_wr && is_gpr;
    // Operand is read in the second quarter; other offsets read zero.
    if (phase_r == pdm_pkg::PH_Q2) begin
      if (is_gpr) rdata_nxt = ram[eff_addr];
      else if (is_sfr_pcl) rdata_nxt = pc_r[7:0];
      else if (is_sfr_status) rdata_nxt = status_r;
      else if (is_sfr_ptr) rdata_nxt = pointer_r;
      else rdata_nxt = pdm_pkg::ZERO_BYTE;
    end
    // Destination written in the fourth quarter; unmapped writes are dropped.
    if (phase_r == pdm_pkg::PH_Q4 && file_wr) begin
      if (is_sfr_status) status_nxt = file_wdata;
      else if (is_sfr_ptr) pointer_nxt = file_wdata;
    end
    // Interrupt wins over a load, a load over a sequential advance.
    if (int_take) begin
      pc_nxt = pdm_pkg::INT_VEC;
    end else if (phase_r == pdm_pkg::PH_Q4 && file_wr && is_sfr_pcl) begin
      pc_nxt = {pc_r[12:8], file_wdata} & pm_mask;
    end else if (pc_load) begin
      pc_nxt = pc_load_value & pm_mask;
    end else if (pc_advance) begin
      pc_nxt = (pc_r + 13'h0001) & pm_mask;
    end
  end

  // Register stage; the RAM is written here in the fourth quarter only.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r <= pdm_pkg::PH_Q1;
      pc_r <= pdm_pkg::RESET_VEC;
      status_r <= pdm_pkg::STATUS_RST;
      pointer_r <= pdm_pkg::POINTER_RST;
      rdata_r <= pdm_pkg::ZERO_BYTE;
    end else begin
      phase_r <= phase_nxt;
      pc_r <= pc_nxt;
      status_r <= status_nxt;
      pointer_r <= pointer_nxt;
      rdata_r <= rdata_nxt;
    end
    if (ram_we) begin
      ram[eff_addr] <= file_wdata;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    fetch_addr = pc_r;
    file_rdata = rdata_r;
    bank_sel = status_r[pdm_pkg::BANK_SEL_HI_BIT:pdm_pkg::BANK_SEL_LO_BIT];
    phase = phase_r;
  end

  // Reset returns the fetch address to the reset vector.
  property p_reset_vec;
    @(posedge ref_clk) rst |=> (fetch_addr == pdm_pkg::RESET_VEC);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

  // A taken interrupt lands on the interrupt vector.
  property p_int_vec;
    @(posedge ref_clk) disable iff (rst) int_take |=> (fetch_addr == pdm_pkg::INT_VEC);
  endproperty
  a_int_vec: assert property (p_int_vec) else $error("interrupt vector wrong");

  // The counter never leaves the implemented range.
  property p_wrap;
    @(posedge ref_clk) disable iff (rst) (fetch_addr & ~pm_mask) == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pc outside program memory");

  // Advance increments modulo size when nothing else intervenes.
  property p_advance;
    @(posedge ref_clk) disable iff (rst)
      (pc_advance && !int_take && !pc_load && !(phase_r == pdm_pkg::PH_Q4 && file_wr))
      |=> fetch_addr == (($past(fetch_addr) + 13'h0001) & pm_mask);
  endproperty
  a_advance: assert property (p_advance) else $error("pc advance wrong");

  // A load with nothing of higher priority lands on the target cut to size.
  property p_load;
    @(posedge ref_clk) disable iff (rst)
      (pc_load && !int_take && !(phase_r == pdm_pkg::PH_Q4 && file_wr && is_sfr_pcl))
      |=> fetch_addr == ($past(pc_load_value) & pm_mask);
  endproperty
  a_load: assert property (p_load) else $error("pc load not cut to size");

  // A low byte write keeps the upper counter bits and replaces the low byte.
  property p_pcl_write;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == pdm_pkg::PH_Q4 && file_wr && is_sfr_pcl && !int_take)
      |=> fetch_addr == ({$past(fetch_addr[12:8]), $past(file_wdata)} & pm_mask);
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("pc low byte write wrong");

  // Phases run Q2, Q3, Q4 in order.
  property p_phase;
    @(posedge ref_clk) disable iff (rst)
      phase == pdm_pkg::PH_Q2 |=> phase == pdm_pkg::PH_Q3 ##1 phase == pdm_pkg::PH_Q4;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order broken");

  // Read data only changes after the second quarter.
  property p_read_q2;
    @(posedge ref_clk) disable iff (rst)
      (!$stable(file_rdata) && !$past(rst)) |-> $past(phase_r) == pdm_pkg::PH_Q2;
  endproperty
  a_read_q2: assert property (p_read_q2) else $error("operand read outside Q2");

  // Bank select follows a fourth-quarter status write.
  property p_bank;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == pdm_pkg::PH_Q4 && file_wr && is_sfr_status) |=>
      bank_sel == $past(file_wdata[pdm_pkg::BANK_SEL_HI_BIT:pdm_pkg::BANK_SEL_LO_BIT]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not updated");

  // Unimplemented offsets read zero.
  property p_zero;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == pdm_pkg::PH_Q2 && !is_gpr && !is_sfr_pcl && !is_sfr_status && !is_sfr_ptr)
      |=> file_rdata == pdm_pkg::ZERO_BYTE;
  endproperty
  a_zero: assert property (p_zero) else $error("unimplemented read not zero");

endmodule // pdm_map

// >>> inc/pdm_pkg.sv
// Package of constants for the program and data memory map block.
package pdm_pkg;
  // Program memory geometry.
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [12:0] PM_MASK_1K = 13'h03FF;
  localparam logic [12:0] PM_MASK_2K = 13'h07FF;
  localparam logic [12:0] PM_MASK_4K = 13'h0FFF;
  localparam logic [12:0] PM_MASK_8K = 13'h1FFF;
  // Program memory size codes used by the size parameter.
  localparam logic [1:0] PM_1K = 2'h0;
  localparam logic [1:0] PM_2K = 2'h1;
  localparam logic [1:0] PM_4K = 2'h2;
  localparam logic [1:0] PM_8K = 2'h3;
  // Data memory geometry.
  localparam int BANK_W = 2;
  localparam int OFS_W = 7;
  localparam int DADDR_W = 9;
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_GPR_LO = 7'h20;
  localparam logic [6:0] OFS_ALIAS_LO = 7'h0C;
  localparam logic [6:0] OFS_ALIAS_HI = 7'h2F;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam int BANK_SEL_HI_BIT = 6;
  localparam int BANK_SEL_LO_BIT = 5;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Instruction cycle phases.
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} pdm_phase_t;
endpackage : pdm_pkg

// >>> dv/pdm_pipe_model.sv
// Pipeline model that drives the map block the way the core's pipeline does.
`timescale 1ns/10ps
module pdm_pipe_model (
  // Clock and block status.
  input wire logic ref_clk,
  input wire logic [1:0] phase,
  input wire logic [7:0] file_rdata,
  // Pipeline requests.
  output logic pc_advance,
  output logic int_take,
  output logic pc_load,
  output logic [12:0] pc_load_value,
  output logic [6:0] file_ofs,
  output logic file_wr,
  output logic [7:0] file_wdata
);
  // All requests start idle so nothing is taken before the bench asks.
  initial begin
    {pc_advance, int_take, pc_load} = 3'h0;
    pc_load_value = 13'h0000;
    file_ofs = 7'h00;
    file_wr = 1'b0;
    file_wdata = 8'h00;
  end
  // One PC request that lasts exactly one clock edge.
  task automatic pc_op(input logic adv, input logic it, input logic ld, input logic [12:0] v);
    @(negedge ref_clk);
    {pc_advance, int_take, pc_load} = {adv, it, ld};
    pc_load_value = v;
    @(negedge ref_clk);
    {pc_advance, int_take, pc_load} = 3'h0;
  endtask
  // One instruction: operand held Q1 to Q4, so a write lands only at the Q4 edge.
  task automatic op(input logic [6:0] ofs, input logic wr, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (phase !== 2'h0 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    file_ofs = ofs;
    file_wr = wr;
    file_wdata = wd;
    repeat (2) @(negedge ref_clk);
    rd = file_rdata;
    // Hold through the Q4 edge, then drop the write so no later Q4 repeats it.
    repeat (2) @(negedge ref_clk);
    file_wr = 1'b0;
  endtask
endmodule // pdm_pipe_model

// >>> dv/program_data_memory_map_tb.sv
// Self-checking bench for the program and data memory map block.
`timescale 1ns/10ps
module program_data_memory_map_tb;
  logic ref_clk, rst, pc_advance, int_take, pc_load, file_wr;
  logic [12:0] pc_load_value, fetch_addr;
  logic [6:0] file_ofs;
  logic [7:0] file_wdata, file_rdata, rd;
  logic [1:0] bank_sel, phase;
  int num_errors, samples_checked;
  // The smallest size is built so that wraparound and bank aliasing both show.
  pdm_map #(.PM_SIZE(pdm_pkg::PM_1K)) uut (.ref_clk(ref_clk), .rst(rst),
    .pc_advance(pc_advance), .int_take(int_take), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .file_ofs(file_ofs), .file_wr(file_wr),
    .file_wdata(file_wdata), .fetch_addr(fetch_addr), .file_rdata(file_rdata),
    .bank_sel(bank_sel), .phase(phase));
  pdm_pipe_model pipe (.ref_clk(ref_clk), .phase(phase), .file_rdata(file_rdata),
    .pc_advance(pc_advance), .int_take(int_take), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .file_ofs(file_ofs), .file_wr(file_wr),
    .file_wdata(file_wdata));
  // Free-running core clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Branch past the top, step over it, then an interrupt beats a branch.
  task automatic t_pc;
    pipe.pc_op(1'b0, 1'b0, 1'b1, 13'h1FFF);
    chk("fetch_addr", 16'h03FF, {3'h0, fetch_addr});
    pipe.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    chk("fetch_addr", 16'h0000, {3'h0, fetch_addr});
    pipe.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    chk("fetch_addr", 16'h0001, {3'h0, fetch_addr});
    pipe.pc_op(1'b0, 1'b1, 1'b1, 13'h0123);
    chk("fetch_addr", 16'h0004, {3'h0, fetch_addr});
  endtask
  // Every bank code, each bank keeping its own top RAM byte.
  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      pipe.op(7'h03, 1'b1, {1'b0, b[1:0], 5'h00}, rd);
      pipe.op(7'h7F, 1'b1, 8'hC0 + 8'(b), rd);
      pipe.op(7'h03, 1'b0, 8'h00, rd);
      chk("status", {9'h0, b[1:0], 5'h00}, {8'h0, rd});
      chk("bank_sel", 16'(b), {14'h0, bank_sel});
    end
    for (int b = 0; b < 4; b++) begin
      pipe.op(7'h03, 1'b1, {1'b0, b[1:0], 5'h00}, rd);
      pipe.op(7'h7F, 1'b0, 8'h00, rd);
      chk("ram_7f", 16'hC0 + 16'(b), {8'h0, rd});
    end
  endtask
  // Bank 1 low RAM is bank 0's; pointer window reads and writes RAM.
  task automatic t_map;
    pipe.op(7'h03, 1'b1, 8'h20, rd);
    pipe.op(7'h2F, 1'b1, 8'hA5, rd);
    pipe.op(7'h03, 1'b1, 8'h00, rd);
    pipe.op(7'h2F, 1'b0, 8'h00, rd);
    chk("alias", 16'h00A5, {8'h0, rd});
    pipe.op(7'h30, 1'b1, 8'h3C, rd);
    pipe.op(7'h04, 1'b1, 8'h30, rd);
    pipe.op(7'h00, 1'b0, 8'h00, rd);
    chk("window_rd", 16'h003C, {8'h0, rd});
    pipe.op(7'h00, 1'b1, 8'h77, rd);
    pipe.op(7'h30, 1'b0, 8'h00, rd);
    chk("window_wr", 16'h0077, {8'h0, rd});
    pipe.op(7'h01, 1'b1, 8'hFF, rd);
    pipe.op(7'h01, 1'b0, 8'h00, rd);
    chk("unimpl", 16'h0000, {8'h0, rd});
    pipe.op(7'h03, 1'b1, 8'h20, rd);
    pipe.op(7'h0C, 1'b1, 8'h55, rd);
    pipe.op(7'h30, 1'b1, 8'h99, rd);
    pipe.op(7'h03, 1'b1, 8'h00, rd);
    pipe.op(7'h0C, 1'b0, 8'h00, rd);
    chk("alias_0c", 16'h0055, {8'h0, rd});
    pipe.op(7'h30, 1'b0, 8'h00, rd);
    chk("bank0_30", 16'h0077, {8'h0, rd});
  endtask
  // A low byte write replaces the counter low byte; core registers read from bank 1.
  task automatic t_pcl;
    pipe.op(7'h02, 1'b1, 8'h5A, rd);
    chk("pcl_wr", 16'h005A, {3'h0, fetch_addr});
    pipe.op(7'h03, 1'b1, 8'h20, rd);
    pipe.op(7'h02, 1'b0, 8'h00, rd);
    chk("pcl_rd", 16'h005A, {8'h0, rd});
    pipe.op(7'h04, 1'b0, 8'h00, rd);
    chk("pointer_rd", 16'h0030, {8'h0, rd});
    chk("phase", 16'h0000, {14'h0, phase});
  endtask
  // Cuts a hang short well beyond the few hundred cycles the tests need.
  initial begin
    #(25 * 5000);
    num_errors++;
    wrap_up;
  end
  initial begin
    rst = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(negedge ref_clk);
    chk("rst_pc", 16'h0000, {3'h0, fetch_addr});
    chk("rst_phase", 16'h0000, {14'h0, phase});
    rst = 1'b0;
    t_pc;
    t_bank;
    t_map;
    t_pcl;
    wrap_up;
  end
endmodule // program_data_memory_map_tb
